// ==== msp_serial_port.sv ====
// Local design decisions: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/100ps
`include "msp_map.svh"
module msp_serial_port
  import msp_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        sclkIn,
  output logic             sclkOut,
  output logic             sclkOe,
  input  wire logic        fsyncIn,
  output logic             fsyncOut,
  output logic             fsyncOe,
  input  wire logic        rxDataIn,
  output logic             txDataOut,
  output logic             txDataOe,
  output logic             rxIrq,
  output logic             txIrq,
  output logic             lenFaultIrq
);
  // ==========================================
  // declarations
  logic        ctrlEn_ff;
  logic        softRst_ff;
  logic [10:0] param_ff;
  logic [9:0]  over_ff;
  logic [10:0] div_ff;
  logic [10:0] icfg_ff;
  logic [15:0] chSel_ff;
  logic [5:0]  stat_ff;
  logic [15:0] txMem [16];
  logic [15:0] rxMem [16];
  logic        wrPend_ff;
  logic [7:0]  wrAddr_ff;
  msp_state_t  state_ff;
  msp_state_t  nxt_state;
  logic [3:0]  slot_ff;
  logic [3:0]  nxt_slot;
  logic [3:0]  bitIdx_ff;
  logic [3:0]  nxt_bitIdx;
  logic [9:0]  overCnt_ff;
  logic [9:0]  nxt_overCnt;
  logic        firstFrame_ff;
  logic        nxt_firstFrame;
  logic        frameEnd;
  logic        syncPrev_ff;
  logic        errPend_ff;
  logic        lateDone_ff;
  logic        rxPend_ff;
  logic        addrPh;
  logic        wrStat;
  logic [5:0]  clrMask;
  logic [5:0]  setMask;
  logic [3:0]  wl;
  logic        master;
  logic        multi;
  logic        longSync;
  logic        alt;
  logic        cont;
  logic        fpol;
  logic        run;
  logic [3:0]  lastSlot;
  logic [3:0]  rxSlot;
  logic [3:0]  txSlot;
  logic        inData;
  logic        used;
  logic        lastBit;
  logic        syncDet;
  logic        syncUse;
  logic        onTime;
  logic        early;
  logic        wordEnd;
  logic        rxEvt;
  logic        txEvt;
  logic        errEvt;
  logic        syncNow;
  logic        txBit;
  logic        txLoad;
  logic [15:0] rxWord;
  logic [10:0] gap_ff;
  logic        gapOk_ff;
  msp_edge_if  edges ();

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  // ==========================================
  // decoded configuration
  assign wl       = param_ff[3:0];
  assign master   = param_ff[`MSP_P_ROLE];
  assign multi    = param_ff[`MSP_P_MULTI];
  assign longSync = param_ff[`MSP_P_LONG];
  assign alt      = param_ff[`MSP_P_ALT];
  assign cont     = param_ff[`MSP_P_CONT];
  assign fpol     = param_ff[`MSP_P_FPOL];
  assign run      = ctrlEn_ff;
  assign lastSlot = multi ? `MSP_LAST_SLOT : 4'h0;
  assign rxSlot   = multi ? icfg_ff[3:0] : 4'h0;
  assign txSlot   = multi ? icfg_ff[7:4] : 4'h0;
  assign inData   = state_ff == ST_DATA;
  assign used     = !multi || chSel_ff[slot_ff];
  assign wordEnd  = inData && bitIdx_ff == wl;

  // ==========================================
  // sub blocks
  msp_clkgen uClk (
    .clock   (clock),
    .rstn    (rstn),
    .run     (run),
    .master  (master),
    .clkPol  (param_ff[`MSP_P_CPOL]),
    .divider (div_ff),
    .sclkIn  (sclkIn),
    .sclkOut (sclkOut),
    .edges   (edges.gen)
  );

  assign txLoad = edges.driveEdge && ((inData && bitIdx_ff == 4'h0) || state_ff == ST_WAIT);
  msp_shifter uShift (
    .clock    (clock),
    .rstn     (rstn),
    .clr      (softRst_ff),
    .load     (txLoad),
    .shift    (edges.driveEdge && inData && bitIdx_ff != 4'h0),
    .loadWord (txMem[inData ? slot_ff : 4'h0]),
    .txBit    (txBit),
    .rxEn     (edges.sampleEdge && (inData || (syncUse && alt))),
    .rxIdx    ((syncUse && alt) ? 4'h0 : bitIdx_ff),
    .rxIn     (rxDataIn),
    .rxWord   (rxWord)
  );

  // ==========================================
  // frame sync detection in slave mode
  assign lastBit = (wordEnd && slot_ff == lastSlot && over_ff == 10'h000)
                || (state_ff == ST_OVER && overCnt_ff == 10'(over_ff - 10'h001));
  assign syncDet = edges.sampleEdge && !master && (fsyncIn ^ fpol) && !syncPrev_ff;
  assign syncUse = syncDet && (state_ff == ST_WAIT
                || (!cont && (inData || state_ff == ST_OVER)));
  assign onTime  = syncUse && (state_ff == ST_WAIT || (!alt && lastBit));
  assign early   = syncUse && !onTime;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) syncPrev_ff <= 1'b0;
    else if (edges.sampleEdge) syncPrev_ff <= fsyncIn ^ fpol;
  end

  // next position in the frame, advanced on sample edges
  always_comb begin
    nxt_state      = state_ff;
    nxt_slot       = slot_ff;
    nxt_bitIdx     = bitIdx_ff;
    nxt_overCnt    = overCnt_ff;
    nxt_firstFrame = firstFrame_ff;
    frameEnd       = 1'b0;
    case (state_ff)
      ST_IDLE: nxt_state = master ? (alt ? ST_DATA : ST_LEAD) : ST_WAIT;
      ST_LEAD: nxt_state = ST_DATA;
      ST_WAIT: nxt_state = ST_WAIT;
      ST_DATA: begin
        if (wordEnd) begin
          nxt_bitIdx = 4'h0;
          if (slot_ff != lastSlot) nxt_slot = 4'(slot_ff + 4'h1);
          else if (over_ff == 10'h000) frameEnd = 1'b1;
          else begin
            nxt_state   = ST_OVER;
            nxt_overCnt = 10'h000;
          end
        end else begin
          nxt_bitIdx = 4'(bitIdx_ff + 4'h1);
        end
      end
      ST_OVER: begin
        if (lastBit) frameEnd = 1'b1;
        else nxt_overCnt = 10'(overCnt_ff + 10'h001);
      end
      default: nxt_state = ST_IDLE;
    endcase
    if (frameEnd) begin
      nxt_firstFrame = 1'b0;
      nxt_slot       = 4'h0;
      nxt_bitIdx     = 4'h0;
      nxt_state      = (master || cont) ? ST_DATA : ST_WAIT;
    end
    if (syncUse) begin
      nxt_slot   = 4'h0;
      nxt_state  = ST_DATA;
      nxt_bitIdx = alt ? 4'h1 : 4'h0;
    end
  end

  // frame engine registers
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_ff      <= ST_IDLE;
      slot_ff       <= 4'h0;
      bitIdx_ff     <= 4'h0;
      overCnt_ff    <= 10'h000;
      firstFrame_ff <= 1'b1;
    end else if (softRst_ff || !run) begin
      state_ff      <= ST_IDLE;
      slot_ff       <= 4'h0;
      bitIdx_ff     <= 4'h0;
      overCnt_ff    <= 10'h000;
      firstFrame_ff <= 1'b1;
    end else if (edges.sampleEdge) begin
      state_ff      <= nxt_state;
      slot_ff       <= nxt_slot;
      bitIdx_ff     <= nxt_bitIdx;
      overCnt_ff    <= nxt_overCnt;
      firstFrame_ff <= nxt_firstFrame;
    end
  end

  // receive store, left aligned, skipping unselected slots
  always_ff @(posedge clock) begin
    if (edges.sampleEdge && wordEnd && !early && used) rxMem[slot_ff] <= rxWord;
  end

  // ==========================================
  // pin drivers, data and frame sync updated on drive edges, clock and sync enables every cycle
  always_comb begin
    if (alt)
      syncNow = inData && slot_ff == 4'h0 && (longSync || bitIdx_ff == 4'h0)
             && (firstFrame_ff || !cont);
    else
      syncNow = state_ff == ST_LEAD || (lastBit && !cont)
             || (longSync && inData && slot_ff == 4'h0 && bitIdx_ff != wl
                 && (firstFrame_ff || !cont));
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      txDataOut <= 1'b0;
      txDataOe  <= 1'b0;
      fsyncOut  <= 1'b0;
      fsyncOe   <= 1'b0;
      sclkOe    <= 1'b0;
    end else begin
      sclkOe  <= run && master;
      fsyncOe <= run && master;
      if (softRst_ff || !run) begin
        txDataOe <= 1'b0;
        fsyncOut <= fpol;
      end else if (edges.driveEdge) begin
        txDataOut <= txBit;
        txDataOe  <= (inData && used)
                  || (state_ff == ST_WAIT && alt && (!multi || chSel_ff[0]));
        fsyncOut  <= master ? syncNow ^ fpol : fpol;
      end
    end
  end

  // ==========================================
  // interrupt events
  assign rxEvt = edges.driveEdge && rxPend_ff;
  assign txEvt = edges.driveEdge && inData && slot_ff == txSlot && bitIdx_ff == 4'h1;
  assign errEvt = (edges.sampleEdge && errPend_ff)
               || (edges.sampleEdge && state_ff == ST_WAIT && !syncUse && !firstFrame_ff
                   && !lateDone_ff && !cont && !master);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rxPend_ff   <= 1'b0;
      errPend_ff  <= 1'b0;
      lateDone_ff <= 1'b0;
    end else if (softRst_ff || !run) begin
      rxPend_ff   <= 1'b0;
      errPend_ff  <= 1'b0;
      lateDone_ff <= 1'b0;
    end else begin
      if (edges.sampleEdge && wordEnd && !early && slot_ff == rxSlot) rxPend_ff <= 1'b1;
      else if (edges.driveEdge) rxPend_ff <= 1'b0;
      if (edges.sampleEdge) errPend_ff <= early;
      if (syncUse) lateDone_ff <= 1'b0;
      else if (errEvt) lateDone_ff <= 1'b1;
    end
  end

  // sticky flags, a set in the clearing cycle wins
  assign wrStat  = wrPend_ff && wrAddr_ff == `MSP_A_STAT;
  assign clrMask = wrStat ? hwdata[5:0] : 6'h00;
  always_comb begin
    setMask = 6'h00;
    setMask[`MSP_S_ERR] = errEvt;
    setMask[`MSP_S_RX]  = rxEvt;
    setMask[`MSP_S_OVF] = rxEvt && stat_ff[`MSP_S_RX];
    setMask[`MSP_S_TX]  = txEvt;
    setMask[`MSP_S_UNF] = txEvt && stat_ff[`MSP_S_TX];
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) stat_ff <= 6'h00;
    else if (softRst_ff) stat_ff <= 6'h00;
    else stat_ff <= (stat_ff & ~clrMask & 6'h3D) | setMask;
  end

  // interrupt lines gated by their unmask bits
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rxIrq       <= 1'b0;
      txIrq       <= 1'b0;
      lenFaultIrq <= 1'b0;
    end else begin
      rxIrq       <= stat_ff[`MSP_S_RX]  && icfg_ff[`MSP_I_UMRX];
      txIrq       <= stat_ff[`MSP_S_TX]  && icfg_ff[`MSP_I_UMTX];
      lenFaultIrq <= stat_ff[`MSP_S_ERR] && icfg_ff[`MSP_I_UMER];
    end
  end

  // ==========================================
  // bus slave, zero wait states, always okay
  assign addrPh = hsel && htrans[1] && hready;

  function automatic logic [31:0] rdMux(input logic [7:0] a);
    case (a)
      `MSP_A_CTRL:  rdMux = 32'(ctrlEn_ff);
      `MSP_A_PARAM: rdMux = 32'(param_ff);
      `MSP_A_OVER:  rdMux = 32'(over_ff);
      `MSP_A_DIV:   rdMux = 32'(div_ff);
      `MSP_A_ICFG:  rdMux = 32'(icfg_ff);
      `MSP_A_CHSEL: rdMux = 32'(chSel_ff);
      `MSP_A_STAT:  rdMux = 32'(stat_ff);
      default: begin
        if (a[7:6] == `MSP_A_TXWIN) rdMux = 32'(txMem[a[5:2]]);
        else if (a[7:6] == `MSP_A_RXWIN) rdMux = 32'(rxMem[a[5:2]]);
        else rdMux = 32'h0000_0000;
      end
    endcase
  endfunction : rdMux

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wrPend_ff <= 1'b0;
      wrAddr_ff <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wrPend_ff <= addrPh && hwrite;
      if (addrPh) wrAddr_ff <= haddr[7:0];
      hrdata    <= (addrPh && !hwrite) ? rdMux(haddr[7:0]) : 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // control register: enable and self clearing soft reset
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ctrlEn_ff  <= 1'b0;
      softRst_ff <= 1'b0;
    end else begin
      softRst_ff <= wrPend_ff && wrAddr_ff == `MSP_A_CTRL && hwdata[`MSP_C_SRST];
      if (wrPend_ff && wrAddr_ff == `MSP_A_CTRL)
        ctrlEn_ff <= hwdata[`MSP_C_EN] && !hwdata[`MSP_C_SRST];
    end
  end

  // parameter registers, locked while the port runs
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      param_ff <= `MSP_RST11;
      over_ff  <= 10'h000;
      div_ff   <= `MSP_RST11;
      icfg_ff  <= `MSP_RST11;
      chSel_ff <= `MSP_RST16;
    end else if (wrPend_ff && !ctrlEn_ff) begin
      case (wrAddr_ff)
        `MSP_A_PARAM: param_ff <= hwdata[10:0];
        `MSP_A_OVER:  over_ff  <= hwdata[9:0];
        `MSP_A_DIV:   div_ff   <= hwdata[10:0];
        `MSP_A_ICFG:  icfg_ff  <= hwdata[10:0];
        `MSP_A_CHSEL: chSel_ff <= hwdata[15:0];
        default:      chSel_ff <= chSel_ff;
      endcase
    end
  end

  // transmit words, writable at any time
  always_ff @(posedge clock) begin
    if (wrPend_ff && wrAddr_ff[7:6] == `MSP_A_TXWIN) txMem[wrAddr_ff[5:2]] <= hwdata[15:0];
  end

  // ==========================================
  // checks
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      gap_ff   <= `MSP_RST11;
      gapOk_ff <= 1'b0;
    end else begin
      gap_ff   <= edges.driveEdge ? 11'h001 : 11'(gap_ff + 11'h001);
      gapOk_ff <= !run ? 1'b0 : (edges.driveEdge ? master : gapOk_ff);
    end
  end

  sequence ackRx;
    wrStat && hwdata[`MSP_S_RX] && !rxEvt;
  endsequence
  sequence rxGone;
    !stat_ff[`MSP_S_RX] ##1 !rxIrq;
  endsequence

  chk_one_slot: assert property (!multi && inData |-> slot_ff == 4'h0)
    else $error("slot advanced in single channel mode");
  chk_word_bound: assert property (inData |-> bitIdx_ff <= wl)
    else $error("bit index passed word length");
  chk_unused_quiet: assert property (
    edges.driveEdge && multi && inData && !chSel_ff[slot_ff] |=> !txDataOe)
    else $error("data driven in unselected slot");
  chk_rx_align: assert property (
    edges.sampleEdge && wordEnd |-> (rxWord & (16'hFFFF >> (5'(wl) + 5'h01))) == 16'h0000)
    else $error("receive low bits not zero");
  chk_err_mask: assert property (!icfg_ff[`MSP_I_UMER] |=> !lenFaultIrq)
    else $error("masked length fault interrupt raised");
  chk_ack_clear: assert property (ackRx |=> rxGone)
    else $error("receive acknowledge did not clear");
  chk_burst_only: assert property (errEvt |-> !cont && !master)
    else $error("length fault outside slave burst mode");
  chk_cont_sync: assert property (
    edges.driveEdge && run && master && cont && !firstFrame_ff && !softRst_ff
    |=> fsyncOut == fpol)
    else $error("sync pulse after first continuous frame");
  chk_div_period: assert property (
    edges.driveEdge && gapOk_ff && master && run |-> gap_ff == div_ff)
    else $error("bit period differs from divider");
  chk_soft_reset: assert property (
    softRst_ff |=> state_ff == ST_IDLE && stat_ff == 6'h00 && !ctrlEn_ff)
    else $error("soft reset left state behind");
endmodule : msp_serial_port

// ==== msp_map.svh ====
`ifndef MSP_MAP_SVH
`define MSP_MAP_SVH
// ==========================================
// register byte offsets
`define MSP_A_CTRL   8'h00
`define MSP_A_PARAM  8'h04
`define MSP_A_OVER   8'h08
`define MSP_A_DIV    8'h0C
`define MSP_A_ICFG   8'h10
`define MSP_A_CHSEL  8'h14
`define MSP_A_STAT   8'h18
`define MSP_A_TXWIN  2'h1
`define MSP_A_RXWIN  2'h2
// ==========================================
// field positions
`define MSP_C_EN     0
`define MSP_C_SRST   1
`define MSP_P_CPOL   4
`define MSP_P_CONT   5
`define MSP_P_ROLE   6
`define MSP_P_MULTI  7
`define MSP_P_LONG   8
`define MSP_P_ALT    9
`define MSP_P_FPOL   10
`define MSP_I_UMRX   8
`define MSP_I_UMTX   9
`define MSP_I_UMER   10
`define MSP_S_ERR    0
`define MSP_S_RX     2
`define MSP_S_OVF    3
`define MSP_S_TX     4
`define MSP_S_UNF    5
// ==========================================
// reset values and counts
`define MSP_RST11    11'h000
`define MSP_RST16    16'h0000
`define MSP_LAST_SLOT 4'hF
`endif

// ==== msp_pkg.sv ====
package msp_pkg;
  // frame engine states
  typedef enum logic [2:0] {ST_IDLE, ST_LEAD, ST_WAIT, ST_DATA, ST_OVER} msp_state_t;
endpackage : msp_pkg

// ==== msp_edge_if.sv ====
`timescale 1ns/100ps
// bit clock edge strobes from the clock generator to the frame engine
interface msp_edge_if;
  logic driveEdge;
  logic sampleEdge;
  modport gen (output driveEdge, output sampleEdge);
  modport eng (input driveEdge, input sampleEdge);
endinterface : msp_edge_if

// ==== msp_clkgen.sv ====
`timescale 1ns/100ps
module msp_clkgen (
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        run,
  input  wire logic        master,
  input  wire logic        clkPol,
  input  wire logic [10:0] divider,
  input  wire logic        sclkIn,
  output logic             sclkOut,
  msp_edge_if.gen          edges
);
  logic [10:0] cnt_ff;
  logic        prev_ff;
  logic        rise_ff;
  logic        fall_ff;
  logic        genOn;
  assign genOn = run & master;
  // divider counter, one bit period per wrap
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) cnt_ff <= `MSP_RST11;
    else if (!genOn || cnt_ff == 11'(divider - 11'h001)) cnt_ff <= `MSP_RST11;
    else cnt_ff <= 11'(cnt_ff + 11'h001);
  end
  // generated clock high for the first half period
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) sclkOut <= 1'b0;
    else if (!genOn) sclkOut <= 1'b0;
    else if (cnt_ff == `MSP_RST11) sclkOut <= 1'b1;
    else if (cnt_ff == (divider >> 1)) sclkOut <= 1'b0;
  end
  // edge pulses, from divider in master or from the pin in slave
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      prev_ff <= 1'b0;
      rise_ff <= 1'b0;
      fall_ff <= 1'b0;
    end else begin
      prev_ff <= sclkIn;
      rise_ff <= run & (master ? cnt_ff == `MSP_RST11 : sclkIn & !prev_ff);
      fall_ff <= run & (master ? cnt_ff == (divider >> 1) : !sclkIn & prev_ff);
    end
  end
  // polarity picks which edge drives and which samples
  assign edges.driveEdge  = clkPol ? fall_ff : rise_ff;
  assign edges.sampleEdge = clkPol ? rise_ff : fall_ff;
endmodule : msp_clkgen

// ==== msp_shifter.sv ====
`timescale 1ns/100ps
module msp_shifter (
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        clr,
  input  wire logic        load,
  input  wire logic        shift,
  input  wire logic [15:0] loadWord,
  output logic             txBit,
  input  wire logic        rxEn,
  input  wire logic [3:0]  rxIdx,
  input  wire logic        rxIn,
  output logic [15:0]      rxWord
);
  logic [15:0] tx_ff;
  logic [15:0] rx_ff;
  // msb first; bit 0 of a word comes straight from the load word
  assign txBit = load ? loadWord[15] : tx_ff[15];
  // receive bit lands left aligned at position 15 - index
  always_comb begin
    rxWord = (rxIdx == 4'h0) ? 16'h0000 : rx_ff;
    rxWord[4'hF - rxIdx] = rxIn;
  end
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tx_ff <= `MSP_RST16;
      rx_ff <= `MSP_RST16;
    end else if (clr) begin
      tx_ff <= `MSP_RST16;
      rx_ff <= `MSP_RST16;
    end else begin
      if (load) tx_ff <= loadWord << 1;
      else if (shift) tx_ff <= tx_ff << 1;
      if (rxEn) rx_ff <= rxWord;
    end
  end
endmodule : msp_shifter

// ==== msp_codec_model.sv ====
`timescale 1ns/100ps
// ==========================================
// codec stand-in: loops the port's slot data back to its receive pin
module msp_codec_model (
  input  wire logic clock,
  input  wire logic rstn,
  input  wire logic txDataOut,
  input  wire logic txDataOe,
  output logic      rxDataIn,
  output logic      sclkIn,
  output logic      fsyncIn
);
  logic       lastBit_ff;
  logic [2:0] phase_ff;
  logic [2:0] bit_ff;
  // line memory, bit clock phase and bit count of an eight bit burst frame
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      lastBit_ff <= 1'b0;
      phase_ff   <= 3'h0;
      bit_ff     <= 3'h0;
    end else begin
      lastBit_ff <= rxDataIn;
      phase_ff   <= 3'(phase_ff + 3'h1);
      if (phase_ff == 3'h7) bit_ff <= 3'(bit_ff + 3'h1);
    end
  end
  // free running bit clock, never gated, so the receive event always arrives
  assign sclkIn  = !phase_ff[2];
  // short normal sync, high during the last bit before channel 0
  assign fsyncIn = bit_ff == 3'h7;
  // echo while driven, toggling pattern while released
  assign rxDataIn = txDataOe ? txDataOut : ~lastBit_ff;
endmodule : msp_codec_model

// ==== msp_serial_port_test.sv ====
`timescale 1ns/100ps
`include "msp_map.svh"
module msp_serial_port_test;
  logic        clock = 1'b0;
  logic        rstn = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] lfsr = 32'h89cc_2abc;
  logic [31:0] rd;
  logic [31:0] hrdata;
  logic        hreadyout, hresp, sclkOut, sclkOe, fsyncOut, fsyncOe;
  logic        rxDataIn, txDataOut, txDataOe, rxIrq, txIrq, lenFaultIrq;
  logic        sclkIn, fsyncIn;
  int          mismatches = 0;
  int          total_checks = 0;
  int          n;
  int          expQ[$];
  // ==========================================
  // clock and design
  always #50 clock = ~clock;
  msp_serial_port DUT (
    .clock(clock), .rstn(rstn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .sclkIn(sclkIn),
    .sclkOut(sclkOut), .sclkOe(sclkOe), .fsyncIn(fsyncIn), .fsyncOut(fsyncOut),
    .fsyncOe(fsyncOe), .rxDataIn(rxDataIn), .txDataOut(txDataOut),
    .txDataOe(txDataOe), .rxIrq(rxIrq), .txIrq(txIrq), .lenFaultIrq(lenFaultIrq)
  );
  msp_codec_model CODEC (
    .clock(clock), .rstn(rstn), .txDataOut(txDataOut), .txDataOe(txDataOe),
    .rxDataIn(rxDataIn), .sclkIn(sclkIn), .fsyncIn(fsyncIn)
  );
  // ==========================================
  // verdict and comparisons
  task automatic report_and_stop();
    if (mismatches == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  // ==========================================
  // bus master: one single word transfer, bounded waits on hready
  task automatic wait_rdy();
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      check(32'h0, 32'h1);
      report_and_stop();
    end
  endtask : wait_rdy
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    haddr <= {24'h00_0000, a};
    hwrite <= wr;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask : bus
  // ==========================================
  // main sequence: master loopback frame
  initial begin
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    bus(1'b0, `MSP_A_ICFG, 32'h0); check(rd, 32'h0);
    bus(1'b1, `MSP_A_PARAM, 32'h0000_0047);
    bus(1'b1, `MSP_A_DIV, 32'h0000_0004);
    bus(1'b1, `MSP_A_ICFG, 32'h0000_0700);
    lfsr = lfsr_next(lfsr);
    expQ.push_back({16'h0000, lfsr[15:8], 8'h00});
    bus(1'b1, 8'h40, lfsr);
    bus(1'b1, `MSP_A_CTRL, 32'h0000_0001);
    bus(1'b1, `MSP_A_PARAM, 32'h0000_0000);
    bus(1'b0, `MSP_A_PARAM, 32'h0); check(rd, 32'h0000_0047);
    for (n = 0; n < 50 && sclkOut !== 1'b0; n++) @(posedge clock);
    for (n = 0; n < 50 && sclkOut !== 1'b1; n++) @(posedge clock);
    for (n = 0; n < 50 && sclkOut === 1'b1; n++) @(posedge clock);
    for (; n < 50 && sclkOut !== 1'b1; n++) @(posedge clock);
    check(n, 32'd4);
    for (n = 0; n < 400 && rxIrq !== 1'b1; n++) @(posedge clock);
    check(n < 400, 32'h1);
    bus(1'b1, `MSP_A_CTRL, 32'h0000_0000);
    bus(1'b0, `MSP_A_STAT, 32'h0); check(rd[2], 1'b1);
    bus(1'b0, 8'h80, 32'h0); check(rd, expQ.pop_front());
    bus(1'b1, `MSP_A_STAT, 32'h0000_0004);
    repeat (2) @(posedge clock);
    check(rxIrq, 1'b0);
    bus(1'b0, 8'h1C, 32'h0); check(rd, 32'h0);
    check(hresp, 1'b0);
    // soft reset, then slave burst frames on the codec's clock
    bus(1'b1, `MSP_A_CTRL, 32'h0000_0002);
    repeat (2) @(posedge clock);
    bus(1'b0, `MSP_A_STAT, 32'h0); check(rd, 32'h0);
    lfsr = lfsr_next(lfsr);
    expQ.push_back({16'h0000, lfsr[15:8], 8'h00});
    bus(1'b1, `MSP_A_PARAM, 32'h0000_0007);
    bus(1'b1, 8'h40, lfsr);
    bus(1'b1, `MSP_A_CTRL, 32'h0000_0001);
    for (n = 0; n < 1000 && rxIrq !== 1'b1; n++) @(posedge clock);
    check(n < 1000, 32'h1);
    check(lenFaultIrq, 1'b0);
    bus(1'b1, `MSP_A_CTRL, 32'h0000_0000);
    bus(1'b0, `MSP_A_STAT, 32'h0); check(rd[0], 1'b0);
    bus(1'b0, 8'h80, 32'h0); check(rd, expQ.pop_front());
    report_and_stop();
  end
endmodule : msp_serial_port_test
